// file: bench/rcs_reset_seq_tb.sv
// Purpose: self-checking bench for reset cause flags, clock choice and reset release
// Assumes: bus answers within 49 clocks, no fixed wait state count; osc_tick every second clock
// Notes: short delay parameters keep the crystal and pll runs brief
module rcs_reset_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int XT = 5;
  localparam int LP = 20;
  localparam int PL = 30;
  localparam int TIMEOUT = 40000;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic por_active = 1'b0;
  logic bor_active = 1'b0;
  logic [4:0] ev = 5'h00;
  logic supply_stable = 1'b1;
  logic osc_tick = 1'b0;
  logic watchdog_fuse_enable = 1'b0;
  logic [2:0] initial_clock_select = rcs_pkg::CLK_EC;
  logic system_reset_signal;
  logic watchdog_enable;
  logic [2:0] current_clock_select;
  logic clock_ready;
  logic irq;
  logic [31:0] rd;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  rcs_reset_seq #(.XTAL_OSCD_CYC(XT), .LOW_POWER_INTERNAL_RC_OSCD_CYC(LP), .PLL_LOCK_CYC(PL)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .por_active(por_active),
    .bor_active(bor_active), .master_clear_pin_n(~ev[4]), .instr_reset_req(ev[0]), .wdt_timeout(ev[1]),
    .wake_from_sleep(ev[2]), .wake_from_idle(ev[3]), .supply_stable(supply_stable), .osc_tick(osc_tick),
    .watchdog_fuse_enable(watchdog_fuse_enable), .initial_clock_select(initial_clock_select),
    .system_reset_signal(system_reset_signal), .watchdog_enable(watchdog_enable),
    .current_clock_select(current_clock_select), .clock_ready(clock_ready), .irq(irq));

  always #5 clk_sys = ~clk_sys;
  // oscillator runs at half the system rate
  always @(posedge clk_sys) osc_tick <= ~osc_tick;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == TIMEOUT) begin
      bad_count++;
      $display("mismatch at %0t: run hung", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // waitrequest sampled at each rising edge; no fixed wait assumed
  task automatic wait_ack();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    chk(k < 50, 1'b1, "bus answer");
  endtask : wait_ack

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  task automatic pulse_ev(input int i);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev <= 5'h00;
  endtask : pulse_ev

  function automatic int exp_delay(input logic [2:0] s);
    case (s)
      rcs_pkg::CLK_FRC: return rcs_pkg::FRC_OSCD_CYC;
      rcs_pkg::CLK_FRCPLL: return rcs_pkg::FRC_OSCD_CYC + PL;
      rcs_pkg::CLK_MS, rcs_pkg::CLK_SOSC: return XT + 2 * rcs_pkg::OST_PERIODS;
      rcs_pkg::CLK_CRYSTAL_WITH_PLL_MODE: return XT + 2 * rcs_pkg::OST_PERIODS + PL;
      rcs_pkg::CLK_ECPLL: return PL;
      rcs_pkg::CLK_LOW_POWER_INTERNAL_RC: return LP;
      default: return 0;
    endcase
  endfunction : exp_delay

  // power or brown-out pulse, optional supply gap, then count cycles to release
  task automatic cold_start(input logic [2:0] s, input bit bor, input int gap);
    int n;
    int lo;
    bit held_bad;
    n = 0;
    held_bad = 0;
    lo = exp_delay(s) + gap;
    @(posedge clk_sys);
    initial_clock_select <= s;
    supply_stable <= (gap == 0);
    if (bor) bor_active <= 1'b1;
    else por_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    por_active <= 1'b0;
    bor_active <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n == gap) supply_stable <= 1'b1;
      if (system_reset_signal !== 1'b1 && (clock_ready !== 1'b1 || supply_stable !== 1'b1)) held_bad = 1;
    end while (system_reset_signal !== 1'b0 && n < 5000);
    chk(held_bad, 0, "released early");
    chk(n >= lo && n <= lo + 8, 1'b1, "start-up delay");
    chk(current_clock_select, s, "cold clock");
  endtask : cold_start

  task automatic t_reset_vals();
    bus_rd(rcs_pkg::ADDR_STATUS, rd);
    chk(rd, 32'h03, "status reset");
    bus_rd(rcs_pkg::ADDR_IRQ_MASK, rd);
    chk(rd, 32'h00, "mask reset");
    bus_rd(rcs_pkg::ADDR_OSC, rd);
    chk(rd & 32'h0F, 32'h0C, "osc after reset");
    bus_wr(4'h2, 32'hFF);
    bus_rd(4'h2, rd);
    chk(rd, 32'h00, "unmapped");
  endtask : t_reset_vals

  // every clock code once; brown-out on the second, supply gap on external clock
  task automatic t_cold();
    for (int s = 0; s < 8; s++) begin
      bus_wr(rcs_pkg::ADDR_STATUS, 32'h00);
      bus_rd(rcs_pkg::ADDR_STATUS, rd);
      chk(rd[1], 1'b0, "brown-out flag idle");
      cold_start(s[2:0], s == 1, (s == 4) ? 20 : 0);
      bus_rd(rcs_pkg::ADDR_STATUS, rd);
      if (s == 1) chk(rd[1], 1'b1, "brown-out flag");
      else chk(rd, 32'h03, "power-on flags");
    end
  endtask : t_cold

  // running clock is low-power rc; config now names another source
  task automatic t_warm();
    int idx[3] = '{0, 1, 4};
    int bits[3] = '{6, 4, 7};
    int n;
    bit saw;
    for (int i = 0; i < 3; i++) begin
      bus_wr(rcs_pkg::ADDR_STATUS, 32'h00);
      bus_wr(rcs_pkg::ADDR_IRQ_STATUS, 32'hFF);
      initial_clock_select <= rcs_pkg::CLK_EC;
      pulse_ev(idx[i]);
      n = 0;
      saw = 0;
      do begin
        @(posedge clk_sys);
        n++;
        if (system_reset_signal === 1'b1) saw = 1;
      end while (!(saw && system_reset_signal === 1'b0) && n < 12);
      chk(saw && n < 8, 1'b1, "warm reset pulse");
      chk(current_clock_select, rcs_pkg::CLK_LOW_POWER_INTERNAL_RC, "warm clock");
      bus_rd(rcs_pkg::ADDR_STATUS, rd);
      chk(rd, 32'h1 << bits[i], "warm cause flag");
      bus_rd(rcs_pkg::ADDR_IRQ_STATUS, rd);
      chk(rd, 32'h1 << bits[i], "event latched");
    end
  endtask : t_warm

  task automatic t_wake();
    bus_wr(rcs_pkg::ADDR_STATUS, 32'h00);
    pulse_ev(2);
    pulse_ev(3);
    repeat (10) @(posedge clk_sys);
    chk(system_reset_signal, 1'b0, "wake is no reset");
    bus_rd(rcs_pkg::ADDR_STATUS, rd);
    chk(rd, 32'h0C, "wake flags sticky");
    bus_wr(rcs_pkg::ADDR_STATUS, 32'h00);
    bus_rd(rcs_pkg::ADDR_STATUS, rd);
    chk(rd, 32'h00, "wake flags cleared");
  endtask : t_wake

  task automatic t_soft();
    bus_wr(rcs_pkg::ADDR_STATUS, 32'hDF);
    repeat (8) @(posedge clk_sys);
    chk(system_reset_signal, 1'b0, "soft set no reset");
    bus_rd(rcs_pkg::ADDR_STATUS, rd);
    chk(rd, 32'hDF, "soft set");
    avs_byteenable <= 4'hE;
    bus_wr(rcs_pkg::ADDR_STATUS, 32'h00);
    avs_byteenable <= 4'hF;
    bus_rd(rcs_pkg::ADDR_STATUS, rd);
    chk(rd, 32'hDF, "lane off keeps flags");
    chk(watchdog_enable, 1'b0, "watchdog off");
    bus_wr(rcs_pkg::ADDR_STATUS, 32'h20);
    @(posedge clk_sys);
    chk(watchdog_enable, 1'b1, "watchdog soft on");
    bus_wr(rcs_pkg::ADDR_STATUS, 32'h00);
    watchdog_fuse_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(watchdog_enable, 1'b1, "watchdog fuse on");
    watchdog_fuse_enable <= 1'b0;
  endtask : t_soft

  task automatic t_irq();
    bus_wr(rcs_pkg::ADDR_IRQ_STATUS, 32'hFF);
    pulse_ev(2);
    bus_rd(rcs_pkg::ADDR_IRQ_STATUS, rd);
    chk(rd, 32'h08, "irq status");
    chk(irq, 1'b0, "irq masked");
    bus_wr(rcs_pkg::ADDR_IRQ_MASK, 32'h08);
    @(posedge clk_sys);
    chk(irq, 1'b1, "irq raised");
    bus_wr(rcs_pkg::ADDR_IRQ_STATUS, 32'h08);
    @(posedge clk_sys);
    chk(irq, 1'b0, "irq cleared");
    bus_wr(rcs_pkg::ADDR_IRQ_MASK, 32'h00);
  endtask : t_irq

  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    do @(posedge clk_sys); while (system_reset_signal !== 1'b0);
    t_reset_vals();
    t_cold();
    t_warm();
    t_wake();
    t_soft();
    t_irq();
    tally_and_finish();
  end
endmodule : rcs_reset_seq_tb

// file: src/rcs_delay_if.sv
// Purpose: start and done handshake between sequencer and delay timer
// Assumes: single clock domain
// Notes: start is a one-cycle pulse, done a level
interface rcs_delay_if;
  logic start;
  logic [2:0] clk_sel;
  logic done;
  modport ctrl (output start, output clk_sel, input done);
  modport timer (input start, input clk_sel, output done);
endinterface : rcs_delay_if

// file: src/rcs_delay_timer.sv
// Purpose: oscillator start-up, start-up timer and pll lock delay chain
// Assumes: osc_tick is one pulse per oscillator period, synchronous
// Notes: a new start restarts the chain from any phase
module rcs_delay_timer #(
  parameter int XTAL_OSCD_CYC = rcs_pkg::XTAL_OSCD_CYC,
  parameter int LOW_POWER_INTERNAL_RC_OSCD_CYC = rcs_pkg::LOW_POWER_INTERNAL_RC_OSCD_CYC,
  parameter int PLL_LOCK_CYC = rcs_pkg::PLL_LOCK_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic osc_tick,
  rcs_delay_if.timer bus
);
  localparam int CW = rcs_pkg::CNT_W;
  typedef enum logic [4:0] {
    TM_IDLE = 5'b00001,
    TM_OSCD = 5'b00010,
    TM_OST = 5'b00100,
    TM_LOCK = 5'b01000,
    TM_DONE = 5'b10000
  } rcs_tm_t;

  rcs_tm_t st_reg, st_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [2:0] sel_reg, sel_next;

  function automatic logic [CW-1:0] oscd_cyc(input logic [2:0] sel);
    if (sel == rcs_pkg::CLK_FRC || sel == rcs_pkg::CLK_FRCPLL) return CW'(rcs_pkg::FRC_OSCD_CYC);
    else if (sel == rcs_pkg::CLK_LOW_POWER_INTERNAL_RC) return CW'(LOW_POWER_INTERNAL_RC_OSCD_CYC);
    else return CW'(XTAL_OSCD_CYC);
  endfunction : oscd_cyc

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sel_next = sel_reg;
    if (bus.start) begin
      sel_next = bus.clk_sel;
      if (rcs_pkg::uses_oscd(bus.clk_sel)) begin
        st_next = TM_OSCD;
        cnt_next = oscd_cyc(bus.clk_sel);
      end else if (rcs_pkg::uses_pll(bus.clk_sel)) begin
        st_next = TM_LOCK;
        cnt_next = CW'(PLL_LOCK_CYC);
      end else begin
        st_next = TM_DONE;
      end
    end else begin
      case (st_reg)
        TM_OSCD: begin
          if (cnt_reg <= CW'(1)) begin
            if (rcs_pkg::uses_ost(sel_reg)) begin
              st_next = TM_OST;
              cnt_next = CW'(rcs_pkg::OST_PERIODS);
            end else if (rcs_pkg::uses_pll(sel_reg)) begin
              st_next = TM_LOCK;
              cnt_next = CW'(PLL_LOCK_CYC);
            end else begin
              st_next = TM_DONE;
            end
          end else begin
            cnt_next = cnt_reg - CW'(1);
          end
        end
        TM_OST: begin
          // counts oscillator periods, not system clocks
          if (osc_tick) begin
            if (cnt_reg <= CW'(1)) begin
              if (rcs_pkg::uses_pll(sel_reg)) begin
                st_next = TM_LOCK;
                cnt_next = CW'(PLL_LOCK_CYC);
              end else begin
                st_next = TM_DONE;
              end
            end else begin
              cnt_next = cnt_reg - CW'(1);
            end
          end
        end
        TM_LOCK: begin
          if (cnt_reg <= CW'(1)) st_next = TM_DONE;
          else cnt_next = cnt_reg - CW'(1);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= TM_IDLE;
      cnt_reg <= '0;
      sel_reg <= rcs_pkg::CLK_RST;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sel_reg <= sel_next;
    end
  end

  assign bus.done = (st_reg == TM_DONE);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  frc_startup_time_a: assert property (bus.start && bus.clk_sel == rcs_pkg::CLK_FRC |=>
    !bus.done ##109 !bus.done ##1 bus.done) else $error("fast rc start-up delay wrong");
  ost_tick_count_a: assert property (st_reg == TM_OST && !osc_tick && !bus.start |=>
    st_reg == TM_OST && cnt_reg == $past(cnt_reg)) else $error("start-up timer moved without tick");
  lock_needs_pll_a: assert property (st_reg == TM_LOCK |-> rcs_pkg::uses_pll(sel_reg))
    else $error("pll lock wait without pll");
  ext_clock_nodelay_a: assert property (bus.start && bus.clk_sel == rcs_pkg::CLK_EC |=> bus.done)
    else $error("external clock added delay");
  ost_phase_c: cover property (st_reg == TM_OST ##1 st_reg == TM_LOCK);
endmodule : rcs_delay_timer

// file: src/rcs_pkg.sv
// Purpose: shared constants for reset cause and clock start-up logic
// Assumes: 100 MHz system clock, 32-bit Avalon-MM register slave
// Notes: clock-select codes are the block's own encoding
package rcs_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W = 20;

  // register byte addresses
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  localparam logic [3:0] ADDR_OSC = 4'hC;

  // reset_cause_status field positions
  localparam int POR_BIT = 0;
  localparam int BOR_BIT = 1;
  localparam int IDLE_BIT = 2;
  localparam int SLEEP_BIT = 3;
  localparam int WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int SOFT_WATCHDOG_ENABLE_BIT = 5;
  localparam int SWR_BIT = 6;
  localparam int PIN_RESET_FLAG_BIT = 7;

  localparam logic [7:0] STATUS_RST = 8'h03;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;

  // clock source selection codes
  localparam logic [2:0] CLK_FRC = 3'h0;
  localparam logic [2:0] CLK_FRCPLL = 3'h1;
  localparam logic [2:0] CLK_MS = 3'h2;
  localparam logic [2:0] CLK_CRYSTAL_WITH_PLL_MODE = 3'h3;
  localparam logic [2:0] CLK_EC = 3'h4;
  localparam logic [2:0] CLK_ECPLL = 3'h5;
  localparam logic [2:0] CLK_SOSC = 3'h6;
  localparam logic [2:0] CLK_LOW_POWER_INTERNAL_RC = 3'h7;
  localparam logic [2:0] CLK_RST = 3'h0;

  // start-up timing; longest times round down
  localparam int FRC_OSCD_NS = 1100;
  localparam int LOW_POWER_INTERNAL_RC_OSCD_NS = 70000;
  localparam int PLL_LOCK_NS = 1500000;
  localparam int OST_PERIODS = 1024;
  localparam int XTAL_OSCD_CYC = 100;
  localparam int FRC_OSCD_CYC = (FRC_OSCD_NS / CLK_PERIOD_NS < 1) ? 1 : FRC_OSCD_NS / CLK_PERIOD_NS;
  localparam int LOW_POWER_INTERNAL_RC_OSCD_CYC = (LOW_POWER_INTERNAL_RC_OSCD_NS / CLK_PERIOD_NS < 1) ? 1 : LOW_POWER_INTERNAL_RC_OSCD_NS / CLK_PERIOD_NS;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS / CLK_PERIOD_NS < 1) ? 1 : PLL_LOCK_NS / CLK_PERIOD_NS;

  function automatic logic uses_pll(input logic [2:0] sel);
    return (sel == CLK_FRCPLL) || (sel == CLK_CRYSTAL_WITH_PLL_MODE) || (sel == CLK_ECPLL);
  endfunction : uses_pll

  function automatic logic uses_ost(input logic [2:0] sel);
    return (sel == CLK_MS) || (sel == CLK_CRYSTAL_WITH_PLL_MODE) || (sel == CLK_SOSC);
  endfunction : uses_ost

  function automatic logic uses_oscd(input logic [2:0] sel);
    return (sel != CLK_EC) && (sel != CLK_ECPLL);
  endfunction : uses_oscd
endpackage : rcs_pkg

// file: src/rcs_reset_seq.sv
// Purpose: reset cause flags, cold and warm reset clock choice, reset release
// Assumes: reset source inputs synchronous to clk_sys; Avalon-MM slave
// Notes: one wait state on every access; readdata stands until next read
// Function
// - reset instruction sets status bit six
// - master clear pin low sets bit seven
// - watchdog time-out reset sets bit four
// - brown-out sets bit one, as does power-on
// - power-on reset sets bit zero
// - software sets/clears flags without causing reset
// - bit five or fuse enables watchdog
// - power-on/brown-out cold, all others warm
// - cold reset loads clock from config field
// - warm reset keeps current clock source
// - hold reset until supplies ready; cold start waits for clock ready unless a warm source or supply loss cuts it short
// - start-up timer lasts 1024 oscillator periods
// - start-up delay 1.1 us / 70 us
// - pll enabled adds 1.5 ms lock
// - delays add up; external clock adds none
module rcs_reset_seq #(
  parameter int XTAL_OSCD_CYC = rcs_pkg::XTAL_OSCD_CYC,
  parameter int LOW_POWER_INTERNAL_RC_OSCD_CYC = rcs_pkg::LOW_POWER_INTERNAL_RC_OSCD_CYC,
  parameter int PLL_LOCK_CYC = rcs_pkg::PLL_LOCK_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic por_active,
  input wire logic bor_active,
  input wire logic master_clear_pin_n,
  input wire logic instr_reset_req,
  input wire logic wdt_timeout,
  input wire logic wake_from_sleep,
  input wire logic wake_from_idle,
  input wire logic supply_stable,
  input wire logic osc_tick,
  input wire logic watchdog_fuse_enable,
  input wire logic [2:0] initial_clock_select,
  output logic system_reset_signal,
  output logic watchdog_enable,
  output logic [2:0] current_clock_select,
  output logic clock_ready,
  output logic irq
);
  typedef enum logic [2:0] {
    SEQ_HOLD = 3'b001,
    SEQ_CLK = 3'b010,
    SEQ_RUN = 3'b100
  } rcs_seq_t;

  rcs_seq_t seq_reg, seq_next;
  logic cold_reg, cold_next;
  logic [2:0] clk_sel_reg, clk_sel_next;
  logic [7:0] status_reg, status_next;
  logic [7:0] irq_stat_reg, irq_stat_next;
  logic [7:0] irq_mask_reg, irq_mask_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic req;
  logic commit;
  logic cold_src;
  logic any_src;
  logic start_pulse;
  logic [7:0] ev;
  logic [7:0] wd8;

  rcs_delay_if dly ();

  rcs_delay_timer #(
    .XTAL_OSCD_CYC(XTAL_OSCD_CYC),
    .LOW_POWER_INTERNAL_RC_OSCD_CYC(LOW_POWER_INTERNAL_RC_OSCD_CYC),
    .PLL_LOCK_CYC(PLL_LOCK_CYC)
  ) u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .osc_tick(osc_tick),
    .bus(dly)
  );

  // lane 0 carries the whole implemented flag byte
  function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] d, input logic [3:0] be);
    return be[0] ? d[7:0] : old;
  endfunction : lane_merge

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign commit = avs_write & ack_reg;
  assign wd8 = avs_writedata[7:0];
  assign cold_src = por_active | bor_active;
  assign any_src = cold_src | ~master_clear_pin_n | instr_reset_req | wdt_timeout;

  always_comb begin
    ev = 8'h00;
    ev[rcs_pkg::POR_BIT] = por_active;
    ev[rcs_pkg::BOR_BIT] = bor_active;
    ev[rcs_pkg::IDLE_BIT] = wake_from_idle;
    ev[rcs_pkg::SLEEP_BIT] = wake_from_sleep;
    ev[rcs_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = wdt_timeout;
    ev[rcs_pkg::SWR_BIT] = instr_reset_req;
    ev[rcs_pkg::PIN_RESET_FLAG_BIT] = ~master_clear_pin_n;
  end

  // register bus: one wait state, data captured on the first edge
  always_comb begin
    ack_next = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read & ~ack_reg) begin
      if (avs_address == rcs_pkg::ADDR_STATUS) begin
        rdata_next = {24'h000000, status_reg};
      end else if (avs_address == rcs_pkg::ADDR_IRQ_STATUS) begin
        rdata_next = {24'h000000, irq_stat_reg};
      end else if (avs_address == rcs_pkg::ADDR_IRQ_MASK) begin
        rdata_next = {24'h000000, irq_mask_reg};
      end else if (avs_address == rcs_pkg::ADDR_OSC) begin
        rdata_next = {24'h000000, 3'h0, cold_reg, clock_ready, clk_sel_reg};
      end else begin
        rdata_next = 32'h00000000;
      end
    end
  end

  // flags: hardware set wins over software clear in the same cycle
  always_comb begin
    status_next = status_reg;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    if (commit && avs_address == rcs_pkg::ADDR_STATUS) begin
      status_next = lane_merge(status_reg, avs_writedata, avs_byteenable);
    end
    if (por_active) begin
      status_next = rcs_pkg::STATUS_RST;
    end
    status_next = status_next | ev;
    if (commit && avs_address == rcs_pkg::ADDR_IRQ_STATUS) begin
      irq_stat_next = irq_stat_reg & ~lane_merge(8'h00, avs_writedata, avs_byteenable);
    end
    irq_stat_next = irq_stat_next | ev;
    if (commit && avs_address == rcs_pkg::ADDR_IRQ_MASK) begin
      irq_mask_next = lane_merge(irq_mask_reg, avs_writedata, avs_byteenable);
    end
  end

  // release sequence; a software write never reaches any_src
  always_comb begin
    seq_next = seq_reg;
    cold_next = cold_reg | cold_src;
    clk_sel_next = clk_sel_reg;
    start_pulse = 1'b0;
    if (cold_src) begin
      clk_sel_next = initial_clock_select;
    end
    case (seq_reg)
      SEQ_HOLD: begin
        if (!any_src && supply_stable) begin
          if (cold_reg) begin
            seq_next = SEQ_CLK;
            start_pulse = 1'b1;
            cold_next = 1'b0;
            clk_sel_next = initial_clock_select;
          end else begin
            seq_next = SEQ_RUN;
          end
        end
      end
      SEQ_CLK: begin
        if (any_src || !supply_stable) seq_next = SEQ_HOLD;
        else if (dly.done) seq_next = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (any_src || !supply_stable) seq_next = SEQ_HOLD;
      end
      default: seq_next = SEQ_HOLD;
    endcase
  end

  assign dly.start = start_pulse;
  assign dly.clk_sel = clk_sel_next;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seq_reg <= SEQ_HOLD;
      cold_reg <= 1'b1;
      clk_sel_reg <= rcs_pkg::CLK_RST;
      status_reg <= rcs_pkg::STATUS_RST;
      irq_stat_reg <= 8'h00;
      irq_mask_reg <= rcs_pkg::IRQ_MASK_RST;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      seq_reg <= seq_next;
      cold_reg <= cold_next;
      clk_sel_reg <= clk_sel_next;
      status_reg <= status_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign system_reset_signal = (seq_reg != SEQ_RUN);
  assign clock_ready = dly.done;
  assign current_clock_select = clk_sel_reg;
  // fuse forces the watchdog on; software can only add to it
  assign watchdog_enable = watchdog_fuse_enable | status_reg[rcs_pkg::SOFT_WATCHDOG_ENABLE_BIT];
  assign irq = |(irq_stat_reg & irq_mask_reg);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  swr_flag_set_a: assert property (instr_reset_req |=> status_reg[rcs_pkg::SWR_BIT])
    else $error("instruction reset flag not set");
  pin_flag_set_a: assert property (!master_clear_pin_n |=> status_reg[rcs_pkg::PIN_RESET_FLAG_BIT])
    else $error("pin reset flag not set");
  wdt_flag_set_a: assert property (wdt_timeout |=> status_reg[rcs_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] && system_reset_signal)
    else $error("watchdog flag or reset missing");
  sleep_flag_hold_a: assert property (status_reg[rcs_pkg::SLEEP_BIT] && !por_active &&
    !(commit && avs_address == rcs_pkg::ADDR_STATUS && avs_byteenable[0]) |=> status_reg[rcs_pkg::SLEEP_BIT])
    else $error("sleep wake flag lost");
  idle_flag_set_a: assert property (wake_from_idle |=> status_reg[rcs_pkg::IDLE_BIT])
    else $error("idle wake flag not set");
  bor_flag_a: assert property (!bor_active && !por_active && !status_reg[rcs_pkg::BOR_BIT] &&
    !(commit && avs_address == rcs_pkg::ADDR_STATUS) |=> !status_reg[rcs_pkg::BOR_BIT])
    else $error("brown-out flag set without cause");
  por_flag_a: assert property (por_active |=> status_reg == (rcs_pkg::STATUS_RST | $past(ev)))
    else $error("power-on did not set flags");
  sw_write_a: assert property (commit && avs_address == rcs_pkg::ADDR_STATUS && avs_byteenable[0] &&
    !any_src && seq_reg == SEQ_RUN && supply_stable |=> status_reg == ($past(wd8) | $past(ev)) && !system_reset_signal)
    else $error("status write wrong or caused reset");
  wdt_enable_a: assert property (watchdog_fuse_enable |-> watchdog_enable)
    else $error("fuse did not force watchdog on");
  cold_clock_a: assert property (cold_src |=> current_clock_select == $past(initial_clock_select))
    else $error("cold reset did not load clock");
  warm_clock_a: assert property (!cold_src && seq_reg != SEQ_HOLD |=> $stable(current_clock_select))
    else $error("warm reset changed clock");
  supply_hold_a: assert property (!supply_stable |=> system_reset_signal)
    else $error("reset released without supply");
  clk_wait_a: assert property (seq_reg == SEQ_CLK && !dly.done |=> system_reset_signal)
    else $error("reset released before clock ready");

  // bus side: one wait state, read data stands between reads
  bus_wait_once_a: assert property (req && avs_waitrequest |=>
    !avs_waitrequest)
    else $error("more than one wait state");
  rdata_stand_a: assert property (!(avs_read && avs_waitrequest) |=>
    $stable(avs_readdata))
    else $error("read data moved without a read");
  read_status_a: assert property (avs_read && avs_waitrequest && avs_address == rcs_pkg::ADDR_STATUS |=>
    avs_readdata == {24'h000000, $past(status_reg)})
    else $error("status read data wrong");
  read_unmapped_a: assert property (avs_read && avs_waitrequest && avs_address[1:0] != 2'h0 |=>
    avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  mask_write_a: assert property (commit && avs_address == rcs_pkg::ADDR_IRQ_MASK && avs_byteenable[0] |=>
    irq_mask_reg == $past(wd8))
    else $error("mask write lost");
  lane_off_a: assert property (commit && avs_address == rcs_pkg::ADDR_STATUS && !avs_byteenable[0] &&
    !por_active && ev == 8'h00 |=> $stable(status_reg))
    else $error("disabled lane changed status");
  // interrupt side: events latch, a one written to a bit clears it
  irq_latch_a: assert property (ev != 8'h00 |=>
    (irq_stat_reg & $past(ev)) == $past(ev))
    else $error("event not latched for interrupt");
  irq_clear_a: assert property (commit && avs_address == rcs_pkg::ADDR_IRQ_STATUS && avs_byteenable[0] |=>
    (irq_stat_reg & $past(wd8) & ~$past(ev)) == 8'h00)
    else $error("interrupt status not cleared");
  irq_spare_bit_a: assert property (
    !irq_stat_reg[rcs_pkg::SOFT_WATCHDOG_ENABLE_BIT])
    else $error("enable bit latched as event");
  // release side: warm sources skip the clock chain, cold ones never do
  src_holds_reset_a: assert property (any_src |=>
    system_reset_signal)
    else $error("reset source did not hold core");
  warm_release_a: assert property (seq_reg == SEQ_HOLD && !cold_reg && !any_src && supply_stable |=>
    !system_reset_signal)
    else $error("warm reset held too long");
  cold_hold_a: assert property (seq_reg == SEQ_HOLD && cold_reg |=>
    system_reset_signal)
    else $error("cold reset skipped clock wait");
  cold_start_a: assert property (seq_reg == SEQ_HOLD && cold_reg && !any_src && supply_stable |->
    dly.start && dly.clk_sel == initial_clock_select)
    else $error("cold release did not start clock chain");
  warm_no_start_a: assert property (!(seq_reg == SEQ_HOLD && cold_reg) |->
    !dly.start)
    else $error("warm path restarted clock chain");
  bor_cold_a: assert property (bor_active |=>
    cold_reg)
    else $error("brown-out not taken as cold");
  instr_warm_a: assert property (instr_reset_req && !cold_src && !cold_reg |=>
    !cold_reg)
    else $error("instruction reset taken as cold");

  cold_start_c: cover property (seq_reg == SEQ_CLK ##[1:300] seq_reg == SEQ_RUN);
  warm_swr_c: cover property (seq_reg == SEQ_RUN ##1 instr_reset_req ##2 seq_reg == SEQ_RUN);
  irq_raise_c: cover property ($rose(irq));
endmodule : rcs_reset_seq
